// ===== verilog/xsr_pkg.sv
// Constants, types and register map of the exception entry unit.
// Assumes a single 25 MHz core clock and word-only AHB-Lite access.
package xsr_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int SRST_MIN_NS = 200;
    localparam int SRST_MIN_CYC = (SRST_MIN_NS * CLK_MHZ + 999) / 1000;
    // ------------------------------------------------------------
    // Machine state word bit positions (bit 0 is the lsb)
    // ------------------------------------------------------------
    localparam int B_POW = 18;
    localparam int B_ILE = 16;
    localparam int B_EE = 15;
    localparam int B_PR = 14;
    localparam int B_FP = 13;
    localparam int B_ME = 12;
    localparam int B_FE0 = 11;
    localparam int B_SE = 10;
    localparam int B_BE = 9;
    localparam int B_FE1 = 8;
    localparam int B_IP = 6;
    localparam int B_IR = 5;
    localparam int B_DR = 4;
    localparam int B_PM = 2;
    localparam int B_RI = 1;
    localparam int B_LE = 0;
    localparam logic [31:0] MSW_IMPL = 32'h0005ff77;
    localparam logic [31:0] MSW_KEEP = 32'h00011040;
    localparam logic [31:0] MSW_ME = 32'h00001000;
    localparam logic [31:0] MSW_RI = 32'h00000002;
    localparam logic [31:0] MSW_RST = 32'h00000040;
    localparam logic [31:0] SSW_COPY = 32'h07c0ffff;
    localparam int B_NHR = 16;
    // ------------------------------------------------------------
    // Vectors
    // ------------------------------------------------------------
    localparam logic [19:0] VEC_OFS_RESET = 20'h00100;
    localparam logic [11:0] VEC_HI = 12'hfff;
    localparam logic [11:0] VEC_LO = 12'h000;
    localparam logic [31:0] RESET_ADDR_HI = 32'hfff00100;
    // ------------------------------------------------------------
    // Register map (byte offsets) and interrupt bits
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_MSW = 5'h00;
    localparam logic [4:0] OFS_SRA = 5'h04;
    localparam logic [4:0] OFS_SSW = 5'h08;
    localparam logic [4:0] OFS_HWC0 = 5'h0c;
    localparam logic [4:0] OFS_VEC = 5'h10;
    localparam logic [4:0] OFS_IST = 5'h14;
    localparam logic [4:0] OFS_IMSK = 5'h18;
    localparam int IRQ_W = 4;
    localparam int IRQ_SOFT = 0;
    localparam int IRQ_MCHK = 1;
    localparam int IRQ_EXC = 2;
    localparam int IRQ_UNREC = 3;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_IDLE = 2'b01,
        ST_DRAIN = 2'b10
    } xsr_state_t;
    typedef struct packed {
        logic valid;
        logic mcheck;
        logic [19:0] vec;
        logic [31:0] pc;
    } xsr_exc_t;
    typedef struct packed {
        logic req;
        logic single;
        logic cinh;
        logic [31:0] addr;
    } xsr_fetch_t;
endpackage

// ===== verilog/xsr_exc_unit.sv
// Exception entry, vectoring and soft reset sequencing of the core.
// Assumes the core presents exceptions, next pc and queue status on
// clk_i; soft reset arrives as an asynchronous active-low pin.
`timescale 1ns/1ps
// What this block does
// RQ1: On any exception entry clear all state bits except three kept ones; machine check entry also clears ME.
// RQ2: On entry copy exception endian mode into endian mode.
// RQ3: Reserved machine state word bits always read zero.
// RQ4: Vector base is low region or all-ones region by prefix bit.
// RQ5: Soft or hard reset raise nonmaskable asynchronous system reset.
// RQ6: Hard reset clears not-hard-reset flag; soft reset keeps it.
// RQ7: First fetch after reset is single-beat, cache-inhibited at 0x100.
// RQ8: Soft reset saves address of the next instruction.
// RQ9: Soft reset drains completion, then saves state and fetches.
// RQ10: Soft reset vector is low or high reset address by prefix.
// RQ11: Soft reset ranks below hard reset and machine check.
// RQ12: Soft reset is recoverable unless draining hit a machine check.
// RQ13: Soft reset pin is edge sensitive with a minimum pulse width.
// RQ14: Soft reset never directly changes the output signals.
// RQ15: Outside logic keeps soft reset quiet during hard reset or test.
// RQ16: Soft reset during or after hard reset assertion is ignored.
// RQ17: Hard reset wins, is nonrecoverable, fetches fixed high address.
// RQ18: After hard reset the machine state word holds only prefix set.
module xsr_exc_unit
#(
    parameter int MIN_CYC = xsr_pkg::SRST_MIN_CYC
)
(
    // Clock and hard reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Soft reset pin
    input wire logic soft_reset_b_i,
    // Core side
    input wire xsr_pkg::xsr_exc_t exc_i,
    input wire logic [31:0] next_pc_i,
    input wire logic queue_empty_i,
    output logic exc_ack_o,
    output logic drain_o,
    output xsr_pkg::xsr_fetch_t fetch_o,
    output logic [31:0] msw_o,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Interrupt
    output logic irq_o
);
    import xsr_pkg::*;

    // Width filter counter is eight bits wide
    if (MIN_CYC < 1 || MIN_CYC > 255)
    begin : g_bad_min
        $error("MIN_CYC out of range");
    end

    // ------------------------------------------------------------
    // Soft reset pin: synchroniser, arm and width filter
    // ------------------------------------------------------------
    logic s1_r, s2_r, armed_r, fired_r;
    logic [7:0] low_cnt_r;
    wire low_long = (low_cnt_r == 8'(MIN_CYC - 1));
    // Armed only after a high level is seen following hard reset, so a
    // pin held low across hard reset never fires. see RQ16 see RQ15
    wire soft_evt = armed_r & ~s2_r & low_long & ~fired_r; // see RQ13

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            // Low, so a pin held low across hard reset is never armed
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end
        else
        begin
            s1_r <= soft_reset_b_i;
            s2_r <= s1_r;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            armed_r <= 1'b0;
            fired_r <= 1'b0;
            low_cnt_r <= 8'h00;
        end
        else
        begin
            armed_r <= armed_r | s2_r; // see RQ16
            fired_r <= ~s2_r & (fired_r | soft_evt); // see RQ13
            low_cnt_r <= s2_r ? 8'h00 : (low_long ? low_cnt_r :
                8'(low_cnt_r + 8'h01));
        end
    end

    // ------------------------------------------------------------
    // Exception arbitration
    // ------------------------------------------------------------
    xsr_state_t st_r, st_nxt;
    logic [31:0] msw_r, sra_r, ssw_r, vec_r;
    logic unrec_r, ack_r;
    wire in_idle = (st_r == ST_IDLE);
    wire in_drain = (st_r == ST_DRAIN);
    // Machine check beats soft reset; other exceptions only before the
    // queue empties. see RQ11
    // A request stays up through its ack cycle; never take it twice
    wire take_mchk = exc_i.valid & exc_i.mcheck & ~ack_r &
        (in_idle | in_drain);
    wire take_soft = in_drain & queue_empty_i & ~take_mchk; // see RQ9
    wire take_oth = exc_i.valid & ~exc_i.mcheck & ~ack_r &
        ((in_idle & ~soft_evt) | (in_drain & ~queue_empty_i));
    wire entry = take_mchk | take_soft | take_oth;
    // ------------------------------------------------------------
    // Entry values
    // ------------------------------------------------------------
    wire [31:0] clr_me = take_mchk ? MSW_ME : 32'h00000000;
    wire [31:0] msw_ent = (msw_r & MSW_KEEP & ~clr_me) |
        {31'h00000000, msw_r[B_ILE]}; // see RQ1 see RQ2
    wire [31:0] clr_ri = (take_soft & unrec_r) ? MSW_RI : 32'h00000000;
    wire [31:0] ssw_ent = msw_r & SSW_COPY & ~clr_ri; // see RQ12
    wire [31:0] pc_ent = take_soft ? next_pc_i : exc_i.pc; // see RQ8
    wire [19:0] ofs_ent = take_soft ? VEC_OFS_RESET : exc_i.vec;
    wire [11:0] base_ent = msw_r[B_IP] ? VEC_HI : VEC_LO; // see RQ4
    wire [31:0] addr_ent = {base_ent, ofs_ent}; // see RQ10

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_BOOT: st_nxt = ST_IDLE;
            ST_IDLE: if (soft_evt) st_nxt = ST_DRAIN; // see RQ5
            ST_DRAIN: if (take_soft) st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Bus slave: reads take one wait state, writes none
    // ------------------------------------------------------------
    logic wr_r, rd_r, hrdy_r, hresp_r;
    logic [4:0] wa_r, ra_r;
    logic [31:0] hrdata_r;
    logic nhr_r;
    logic [IRQ_W-1:0] ist_r, imsk_r;
    logic irq_r;
    wire ap_valid = hsel_i & hready_i & htrans_i[1];
    wire wr_msw = wr_r & (wa_r == OFS_MSW);
    wire wr_sra = wr_r & (wa_r == OFS_SRA);
    wire wr_ssw = wr_r & (wa_r == OFS_SSW);
    wire wr_hwc = wr_r & (wa_r == OFS_HWC0);
    wire wr_imsk = wr_r & (wa_r == OFS_IMSK);
    wire rd_ist = rd_r & (ra_r == OFS_IST);
    wire [31:0] hwc_rd = {15'h0000, nhr_r, 16'h0000};
    wire [31:0] ist_rd = {28'h0000000, ist_r};
    wire [31:0] imsk_rd = {28'h0000000, imsk_r};
    wire [31:0] rd_mux =
        (ra_r == OFS_MSW) ? msw_r :
        (ra_r == OFS_SRA) ? sra_r :
        (ra_r == OFS_SSW) ? ssw_r :
        (ra_r == OFS_HWC0) ? hwc_rd :
        (ra_r == OFS_VEC) ? vec_r :
        (ra_r == OFS_IST) ? ist_rd :
        (ra_r == OFS_IMSK) ? imsk_rd : 32'h00000000;
    wire [IRQ_W-1:0] ev = {take_soft & unrec_r, take_oth, take_mchk,
        take_soft};
    // Event wins over the read that clears it
    wire [IRQ_W-1:0] ist_nxt = (rd_ist ? '0 : ist_r) | ev;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            wa_r <= 5'h00;
            ra_r <= 5'h00;
            hrdy_r <= 1'b1;
            hresp_r <= 1'b0;
            hrdata_r <= 32'h00000000;
        end
        else
        begin
            wr_r <= ap_valid & hwrite_i;
            rd_r <= ap_valid & ~hwrite_i;
            if (ap_valid)
            begin
                wa_r <= haddr_i[4:0];
                ra_r <= haddr_i[4:0];
            end
            hrdy_r <= ~(ap_valid & ~hwrite_i);
            hresp_r <= 1'b0;
            if (rd_r)
                hrdata_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Architectural state; entry beats a software write
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            msw_r <= MSW_RST; // see RQ18
            sra_r <= 32'h00000000;
            ssw_r <= 32'h00000000;
            vec_r <= 32'h00000000;
            nhr_r <= 1'b0; // see RQ6
            unrec_r <= 1'b0;
        end
        else
        begin
            if (entry)
            begin
                msw_r <= msw_ent;
                sra_r <= pc_ent;
                ssw_r <= ssw_ent;
                vec_r <= addr_ent;
            end
            else
            begin
                if (wr_msw)
                    msw_r <= hwdata_i & MSW_IMPL; // see RQ3
                if (wr_sra)
                    sra_r <= hwdata_i;
                if (wr_ssw)
                    ssw_r <= hwdata_i & SSW_COPY;
            end
            // Soft reset leaves the flag alone. see RQ6
            if (wr_hwc)
                nhr_r <= hwdata_i[B_NHR];
            unrec_r <= (unrec_r & ~take_soft) | (take_mchk & in_drain);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ist_r <= '0;
            imsk_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            ist_r <= ist_nxt;
            if (wr_imsk)
                imsk_r <= hwdata_i[IRQ_W-1:0];
            irq_r <= |(ist_nxt & imsk_r);
        end
    end

    // ------------------------------------------------------------
    // Sequencer and core-facing outputs
    // ------------------------------------------------------------
    xsr_fetch_t fetch_r;
    logic drain_r;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= ST_BOOT;
            fetch_r <= '0;
            drain_r <= 1'b0;
            ack_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            drain_r <= (st_nxt == ST_DRAIN); // see RQ9
            ack_r <= take_mchk | take_oth;
            fetch_r.req <= (st_r == ST_BOOT) | entry;
            // Reset fetches go out single-beat and uncached. see RQ7
            fetch_r.single <= (st_r == ST_BOOT) | take_soft;
            fetch_r.cinh <= (st_r == ST_BOOT) | take_soft;
            if (st_r == ST_BOOT)
                fetch_r.addr <= RESET_ADDR_HI; // see RQ17
            else if (entry)
                fetch_r.addr <= addr_ent;
        end
    end

    // Soft reset reaches the outputs only through registered state: drain_o
    // rises the cycle after the event, fetch_o and msw_o change at entry. see RQ14
    assign exc_ack_o = ack_r;
    assign drain_o = drain_r;
    assign fetch_o = fetch_r;
    assign msw_o = msw_r;
    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hrdy_r;
    assign hresp_o = hresp_r;
    assign irq_o = irq_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    boot_fetch_a: assert property ((st_r == ST_BOOT && rst_b_i) |=> // see RQ17
        (fetch_r.req && fetch_r.single && fetch_r.addr == RESET_ADDR_HI))
        else $error("boot fetch wrong");
    entry_clear_a: assert property (entry |=> // see RQ1
        ((msw_r & ~MSW_KEEP & ~32'h00000001) == 32'h00000000))
        else $error("entry left bits set");
    endian_copy_a: assert property (entry |=> // see RQ2
        (msw_r[B_LE] == $past(msw_r[B_ILE])))
        else $error("endian not copied");
    mchk_me_a: assert property (take_mchk |=> !msw_r[B_ME]) // see RQ1
        else $error("machine check kept enable");
    rsvd_zero_a: assert property // see RQ3
        ((msw_r & ~MSW_IMPL) == 32'h00000000)
        else $error("reserved bit set");
    vec_base_a: assert property (entry |=> // see RQ4
        (fetch_r.addr[31:20] == ($past(msw_r[B_IP]) ? VEC_HI : VEC_LO)))
        else $error("vector base wrong");
    soft_vec_a: assert property (take_soft |=> // see RQ10
        (fetch_r.cinh && fetch_r.addr[19:0] == VEC_OFS_RESET))
        else $error("soft vector wrong");
    soft_drain_a: assert property ((soft_evt && in_idle) |=> // see RQ9
        (drain_r && !fetch_r.req))
        else $error("soft reset did not drain");
    soft_pc_a: assert property (take_soft |=> // see RQ8
        (sra_r == $past(next_pc_i)))
        else $error("return address wrong");
    unrec_ri_a: assert property ((take_soft && unrec_r) |=> // see RQ12
        !ssw_r[B_RI])
        else $error("unrecoverable soft reset marked recoverable");
    mchk_prio_a: assert property ((in_drain && queue_empty_i && // see RQ11
        exc_i.valid && exc_i.mcheck && !ack_r) |=>
        (exc_ack_o && drain_r))
        else $error("soft reset beat machine check");
    pulse_wide_a: assert property (soft_evt |-> // see RQ13
        (!s2_r && armed_r && (MIN_CYC < 2 || $past(!s2_r))))
        else $error("soft reset pulse too short");
    nhr_keep_a: assert property ((take_soft && !wr_hwc) |=> // see RQ6
        $stable(nhr_r))
        else $error("soft reset changed flag");
    read_wait_a: assert property ((ap_valid && !hwrite_i) |=>
        (!hreadyout_o ##1 hreadyout_o))
        else $error("read wait state wrong");

    soft_seq_c: cover property (soft_evt ##[1:20] take_soft);
    mchk_drain_c: cover property (take_mchk && in_drain);
    irq_c: cover property ($rose(irq_o));
    ist_race_c: cover property (rd_ist && (|ev));
endmodule // xsr_exc_unit

// ===== verif/xsr_reset_src.sv
// Board-level reset logic model: drives the soft reset pin.
// Assumes the bench pulses fire_i for one cycle per requested reset.
`timescale 1ns/1ps
module xsr_reset_src
#(
    parameter int W = 4
)
(
    // Clock and hard reset seen by the board
    input wire logic clk_i,
    input wire logic hard_b_i,
    // Bench commands
    input wire logic fire_i,
    input wire logic rude_i,
    // Soft reset pin
    output logic soft_reset_b_o
);
    int cnt;
    initial
    begin
        soft_reset_b_o = 1'b1;
        cnt = 0;
    end
    // ----------------------------------------
    // Pulse generator
    // ----------------------------------------
    // Pulse held W cycles, above the bench MIN_CYC of 2, below the 5-cycle default minimum
    // Quiet during hard reset unless told to misbehave
    always @(posedge clk_i)
    begin
        if (cnt > 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
                soft_reset_b_o <= 1'b1;
        end
        else if (fire_i && (hard_b_i || rude_i))
        begin
            cnt <= W;
            soft_reset_b_o <= 1'b0;
        end
    end
endmodule // xsr_reset_src

// ===== verif/xsr_exc_unit_tb.sv
// Self-checking bench of the exception entry unit.
// Assumes the partner model xsr_reset_src and AHB-Lite register access.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    bad_count++; $display("Error %s exp %h got %h", nm, ex, got); end end
module xsr_exc_unit_tb;
    import xsr_pkg::*;
    logic clk_i = 0, rst_b_i = 0, soft_b, fire = 0, rude = 0, qe = 0;
    logic hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq, ack, drain;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, npc = 0, msw, rd, m;
    xsr_exc_t exc = '0;
    xsr_fetch_t fetch;
    int bad_count = 0, num_checks = 0, seed = 32'hb2a0, i, n;
    assign hready = hreadyout;
    always #20 clk_i = ~clk_i;
    xsr_reset_src #(.W(4)) xsr_reset_src_i (.clk_i(clk_i), .hard_b_i(rst_b_i),
        .fire_i(fire), .rude_i(rude), .soft_reset_b_o(soft_b));
    xsr_exc_unit #(.MIN_CYC(2)) xsr_exc_unit_i (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .soft_reset_b_i(soft_b), .exc_i(exc),
        .next_pc_i(npc), .queue_empty_i(qe), .exc_ack_o(ack),
        .drain_o(drain), .fetch_o(fetch), .msw_o(msw), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .irq_o(irq));
    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic logic [31:0] exp_msw(logic [31:0] v, logic mc);
        return (v & MSW_KEEP & ~(mc ? MSW_ME : 32'h0)) | {31'h0, v[B_ILE]};
    endfunction
    function automatic logic [31:0] exp_vec(logic ip, logic [19:0] ofs);
        return {ip ? VEC_HI : VEC_LO, ofs};
    endfunction
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] wd);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic hard_rst(input logic late);
        rst_b_i <= 1'b0;
        repeat (15) @(posedge clk_i);
        // Optional soft pulse that starts in and outlasts the hard reset
        fire <= late;
        rude <= late;
        @(posedge clk_i);
        fire <= 1'b0;
        rude <= 1'b0;
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK("boot req", 3'h7, {fetch.req, fetch.single, fetch.cinh})
        `CHK("boot addr", RESET_ADDR_HI, fetch.addr)
        `CHK("boot msw", MSW_RST, msw)
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        hard_rst(1'b0);
        bus(1, OFS_MSW, 32'hffffffff);
        bus(0, OFS_MSW, 0);
        `CHK("msw rsvd", MSW_IMPL, rd)
        bus(0, 5'h1c, 0);
        `CHK("unmapped", 32'h0, rd)
        // Random core exceptions with the interrupt masked off
        for (n = 0; n < 12; n++)
        begin
            m = $random(seed) & MSW_IMPL;
            bus(1, OFS_MSW, m);
            @(posedge clk_i);
            exc <= {1'b1, 1'($random(seed)), 20'($random(seed)),
                    32'($random(seed))};
            do @(posedge clk_i); while (ack !== 1'b1);
            exc.valid <= 1'b0;
            `CHK("exc msw", exp_msw(m, exc.mcheck), msw)
            `CHK("exc vec", exp_vec(m[B_IP], exc.vec), fetch.addr)
            `CHK("irq masked", 1'b0, irq)
            bus(0, OFS_SSW, 0);
            `CHK("ssw", m & SSW_COPY, rd)
        end
        bus(1, OFS_HWC0, 32'h1 << B_NHR);
        bus(0, OFS_IST, 0);
        bus(1, OFS_IMSK, 32'h1);
        // Soft reset at both prefix settings, with a slow queue drain
        for (n = 0; n < 2; n++)
        begin
            m = ($random(seed) & MSW_IMPL & ~(32'h1 << B_IP)) | MSW_RI;
            m[B_IP] = n[0];
            bus(1, OFS_MSW, m);
            @(posedge clk_i);
            npc <= $random(seed);
            fire <= 1'b1;
            @(posedge clk_i);
            fire <= 1'b0;
            for (i = 0; i < 20 && drain !== 1'b1; i++) @(posedge clk_i);
            `CHK("drain", 1'b1, drain)
            repeat (4)
            begin
                @(posedge clk_i);
                `CHK("no early fetch", 1'b0, fetch.req)
            end
            if (n == 1)
            begin
                // Machine check as the queue empties beats soft reset
                exc <= {1'b1, 1'b1, 20'h00200, 32'h00000000};
                qe <= 1'b1;
                do @(posedge clk_i); while (ack !== 1'b1);
                exc.valid <= 1'b0;
                `CHK("mchk first", 1'b1, drain)
                @(posedge clk_i);
            end
            qe <= 1'b1;
            for (i = 0; i < 20 && fetch.req !== 1'b1; i++) @(posedge clk_i);
            qe <= 1'b0;
            `CHK("srst kind", 3'h7, {fetch.req, fetch.single, fetch.cinh})
            `CHK("srst vec", exp_vec(n[0], VEC_OFS_RESET), fetch.addr)
            `CHK("srst msw", exp_msw(m, n[0]), msw)
            repeat (2) @(posedge clk_i);
            `CHK("irq", 1'b1, irq)
            bus(0, OFS_SRA, 0);
            `CHK("sra", npc, rd)
            bus(0, OFS_SSW, 0);
            `CHK("ssw ri", !n[0], rd[B_RI])
            bus(0, OFS_IST, 0);
            `CHK("ist", (n[0] ? 32'hb : 32'h1), rd)
            bus(0, OFS_HWC0, 0);
            `CHK("nhr kept", 1'b1, rd[B_NHR])
            @(posedge clk_i);
            `CHK("irq clear", 1'b0, irq)
        end
        // Soft reset pulsed inside a hard reset must leave no trace
        rst_b_i <= 1'b0;
        @(posedge clk_i);
        rude <= 1'b1;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        rude <= 1'b0;
        hard_rst(1'b1);
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            `CHK("ignored", 1'b0, drain)
        end
        bus(0, OFS_HWC0, 0);
        `CHK("nhr clear", 1'b0, rd[B_NHR])
        give_verdict();
    end
endmodule // xsr_exc_unit_tb
